//--- core/pmic_lp_pkg.sv
// package: constants and carrier types for the low power reset controller
package pmic_lp_pkg;

	// ----------------------------------------------------------------
	// sequencing step timing
	// ----------------------------------------------------------------
	localparam int STEP_TIME_US = 1;
	localparam int CLK_MHZ = 100;
	localparam int STEP_CYCLES = STEP_TIME_US * CLK_MHZ;
	localparam int RAIL_COUNT = 4;
	localparam logic [3:0] RAILS_NONE = 4'h0;
	localparam logic [3:0] RAILS_ALL = 4'hF;

	// ----------------------------------------------------------------
	// rail bit positions
	// ----------------------------------------------------------------
	localparam int RAIL_AO_CORE = 0;
	localparam int RAIL_AO_IO = 1;
	localparam int RAIL_CORE = 2;
	localparam int RAIL_ANALOG = 3;
	localparam logic [3:0] RAILS_STANDBY_OFF = 4'hC;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_POWER_UP = 3'b001,
		ST_ACTIVE = 3'b010,
		ST_STANDBY = 3'b011,
		ST_POWER_DOWN = 3'b100
	} ctrl_state_t;

	// open-drain pin: out low while oe high
	typedef struct packed {
		logic out;
		logic oe;
	} od_pin_t;

	typedef struct packed {
		logic [3:0] enable;
		logic forced_pwm;
	} rail_ctrl_t;

endpackage : pmic_lp_pkg

//--- core/pmic_low_power_reset_control.sv
// module: power controller sequencing, rail gating and wired reset network
`timescale 1ns/100ps
// ------------------------------------------------------------------
// What this block does
// [R1] enable high runs power-on sequence
// [R2] enable low runs power-down sequence
// [R3] mode high: active, all rails, forced pwm
// [R4] mode low: standby, core/analog off, pfm
// [R5] first output: always-on power good
// [R6] always-on power good released in standby
// [R7] second output enables external io regulator
// [R8] main reset joins controller and io good
// [R9] processor drives mode low for retention
// [R10] processor drops enable to turn all rails off
// [R11] discrete always-on goods drive always-on reset
// [R12] buffer pulls main reset on always-on fault
// [R13] main reset wires three contributors together
// [R14] power-down from pin or software off
// [R15] reset lines are wired-and open-drain
// [R16] enable and mode two-flop synchronized
// ------------------------------------------------------------------
module pmic_low_power_reset_control
	import pmic_lp_pkg::*;
#(
	parameter int STEP_CYCLES_P = STEP_CYCLES,
	parameter bit FLEXIBLE_P = 1'b0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// processor control pins
	input wire logic controller_enable_in,
	input wire logic mode_standby_in,
	input wire logic sw_off_request,
	// power-good feedback
	input wire logic [3:0] rail_good_in,
	input wire logic io_regulator_good_in,
	input wire logic ao_discrete_good_in,
	// rails
	output rail_ctrl_t rail_ctrl,
	output ctrl_state_t ctrl_state,
	// open-drain outputs
	output od_pin_t always_on_power_good_out,
	output od_pin_t io_regulator_enable_out,
	output od_pin_t controller_reset_out_n,
	output od_pin_t ao_buffer_out,
	// resolved reset levels
	output logic main_power_on_reset_n,
	output logic always_on_power_on_reset_n
);

	// ----------------------------------------------------------------
	// input synchronizers
	// ----------------------------------------------------------------
	logic [1:0] en_sync_reg, en_sync_next;
	logic [1:0] mode_sync_reg, mode_sync_next;
	logic en_s, mode_s;

	// [R16] two-flop chain
	always_comb begin
		en_sync_next = {en_sync_reg[0], controller_enable_in};
		mode_sync_next = {mode_sync_reg[0], mode_standby_in};
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			en_sync_reg <= 2'h0;
			mode_sync_reg <= 2'h0;
		end else begin
			en_sync_reg <= en_sync_next;
			mode_sync_reg <= mode_sync_next;
		end
	end

	assign en_s = en_sync_reg[1];
	assign mode_s = mode_sync_reg[1];

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	ctrl_state_t state_reg, state_next;
	logic [3:0] rails_reg, rails_next;
	logic [15:0] step_reg, step_next;
	logic pwm_reg, pwm_next;
	logic off_req;
	logic step_done;

	// [R14] hardware or software off
	assign off_req = !en_s || sw_off_request;
	assign step_done = (step_reg == 16'(STEP_CYCLES_P - 1));

	always_comb begin
		state_next = state_reg;
		rails_next = rails_reg;
		step_next = 16'h0;
		pwm_next = pwm_reg;
		unique case (state_reg)
			ST_OFF: begin
				rails_next = RAILS_NONE;
				// [R1] start power-on
				if (!off_req)
					state_next = ST_POWER_UP;
			end
			ST_POWER_UP: begin
				step_next = step_done ? 16'h0 : step_reg + 16'h1;
				pwm_next = 1'b1;
				if (off_req) begin
					state_next = ST_POWER_DOWN;
				end else if (rails_reg == RAILS_ALL) begin
					state_next = ST_ACTIVE;
				end else if (step_done) begin
					// rails come up one per step, always-on first
					rails_next = {rails_reg[2:0], 1'b1};
				end
			end
			ST_ACTIVE: begin
				// [R3] all rails, forced pwm
				rails_next = RAILS_ALL;
				pwm_next = 1'b1;
				if (off_req)
					state_next = ST_POWER_DOWN;
				else if (!mode_s) begin
					// standby rails and pfm land with the state, never a cycle late
					state_next = ST_STANDBY;
					rails_next = RAILS_ALL & ~RAILS_STANDBY_OFF;
					pwm_next = 1'b0;
				end
			end
			ST_STANDBY: begin
				// [R4] core and analog off, auto pfm
				rails_next = rails_reg & ~RAILS_STANDBY_OFF;
				pwm_next = 1'b0;
				if (off_req)
					state_next = ST_POWER_DOWN;
				else if (mode_s) begin
					rails_next = RAILS_ALL;
					pwm_next = 1'b1;
					state_next = ST_ACTIVE;
				end
			end
			ST_POWER_DOWN: begin
				// [R2] rails off in reverse order
				step_next = step_done ? 16'h0 : step_reg + 16'h1;
				if (rails_reg == RAILS_NONE)
					state_next = ST_OFF;
				else if (step_done)
					rails_next = {1'b0, rails_reg[3:1]};
			end
			default: begin
				state_next = ST_OFF;
				rails_next = RAILS_NONE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_OFF;
			rails_reg <= RAILS_NONE;
			step_reg <= 16'h0;
			pwm_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			rails_reg <= rails_next;
			step_reg <= step_next;
			pwm_reg <= pwm_next;
		end
	end

	assign rail_ctrl = '{enable: rails_reg, forced_pwm: pwm_reg};
	assign ctrl_state = state_reg;

	// ----------------------------------------------------------------
	// open-drain outputs
	// ----------------------------------------------------------------
	logic ao_good_pull_reg, ao_good_pull_next;
	logic io_en_pull_reg, io_en_pull_next;
	logic ctrl_rst_pull_reg, ctrl_rst_pull_next;
	logic ao_good;

	assign ao_good = rail_good_in[RAIL_AO_CORE] && rail_good_in[RAIL_AO_IO];

	always_comb begin
		// [R5] always-on power good pin
		ao_good_pull_next = !ao_good;
		// [R6] released during standby
		if (state_reg == ST_STANDBY)
			ao_good_pull_next = 1'b0;
		// [R7] external io regulator enable, low turns it off
		io_en_pull_next = !(state_reg == ST_ACTIVE || state_reg == ST_STANDBY ||
			(state_reg == ST_POWER_UP && rails_reg[RAIL_AO_IO]));
		// [R9] standby holds the main reset low
		ctrl_rst_pull_next = (state_reg != ST_ACTIVE) || (rails_reg != RAILS_ALL);
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ao_good_pull_reg <= 1'b1;
			io_en_pull_reg <= 1'b1;
			ctrl_rst_pull_reg <= 1'b1;
		end else begin
			ao_good_pull_reg <= ao_good_pull_next;
			io_en_pull_reg <= io_en_pull_next;
			ctrl_rst_pull_reg <= ctrl_rst_pull_next;
		end
	end

	assign always_on_power_good_out = '{out: 1'b0, oe: ao_good_pull_reg};
	assign io_regulator_enable_out = '{out: 1'b0, oe: io_en_pull_reg};
	assign controller_reset_out_n = '{out: 1'b0, oe: ctrl_rst_pull_reg};

	// ----------------------------------------------------------------
	// wired reset network
	// ----------------------------------------------------------------
	// [R11] [R15] always-on reset source per arrangement
	assign always_on_power_on_reset_n = FLEXIBLE_P ? ao_discrete_good_in : !ao_good_pull_reg;
	// [R12] buffer mirrors always-on reset onto main reset
	assign ao_buffer_out = '{out: 1'b0, oe: FLEXIBLE_P && !ao_discrete_good_in};
	// [R8] [R13] [R15] wired-and of all contributors
	assign main_power_on_reset_n = !ctrl_rst_pull_reg && io_regulator_good_in &&
		!(FLEXIBLE_P && !ao_discrete_good_in);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_power_up_start;
		@(posedge sys_clk) disable iff (reset)
		(state_reg == ST_OFF && !off_req) |=> state_reg == ST_POWER_UP;
	endproperty
	a_power_up_start: assert property (p_power_up_start) // [R1]
		else $error("power-up not started");

	property p_off_goes_down;
		@(posedge sys_clk) disable iff (reset)
		(state_reg == ST_ACTIVE && off_req) |=> state_reg == ST_POWER_DOWN;
	endproperty
	a_off_goes_down: assert property (p_off_goes_down) // [R2]
		else $error("power-down not started");

	property p_active_rails;
		@(posedge sys_clk) disable iff (reset)
		(state_reg == ST_ACTIVE) |-> (rails_reg == RAILS_ALL && pwm_reg);
	endproperty
	a_active_rails: assert property (p_active_rails) // [R3]
		else $error("active without all rails or pwm");

	property p_standby_rails;
		@(posedge sys_clk) disable iff (reset)
		(state_reg == ST_STANDBY) |-> (!rails_reg[RAIL_CORE] && !rails_reg[RAIL_ANALOG]
			&& !pwm_reg);
	endproperty
	a_standby_rails: assert property (p_standby_rails) // [R4]
		else $error("standby rails wrong");

	property p_ao_good_follows;
		@(posedge sys_clk) disable iff (reset)
		(state_reg != ST_STANDBY && !ao_good) |=> always_on_power_good_out.oe;
	endproperty
	a_ao_good_follows: assert property (p_ao_good_follows) // [R5]
		else $error("always-on good not pulled on bad rail");

	property p_standby_release;
		@(posedge sys_clk) disable iff (reset)
		(state_reg == ST_STANDBY) |=> !always_on_power_good_out.oe;
	endproperty
	a_standby_release: assert property (p_standby_release) // [R6]
		else $error("always-on good pulled in standby");

	property p_main_wired;
		@(posedge sys_clk) disable iff (reset)
		(!io_regulator_good_in || controller_reset_out_n.oe) |-> !main_power_on_reset_n;
	endproperty
	a_main_wired: assert property (p_main_wired) // [R15]
		else $error("main reset released with contributor low");

	property p_sync_delay;
		@(posedge sys_clk) disable iff (reset)
		$rose(controller_enable_in) ##1 controller_enable_in |=> en_s;
	endproperty
	a_sync_delay: assert property (p_sync_delay) // [R16]
		else $error("enable sync latency wrong");

	property p_sw_off;
		@(posedge sys_clk) disable iff (reset)
		(state_reg inside {ST_POWER_UP, ST_ACTIVE, ST_STANDBY} && sw_off_request)
			|=> state_reg == ST_POWER_DOWN;
	endproperty
	a_sw_off: assert property (p_sw_off) // [R14]
		else $error("software off ignored");

	property p_io_off_when_down;
		@(posedge sys_clk) disable iff (reset)
		(state_reg == ST_OFF) |=> io_regulator_enable_out.oe;
	endproperty
	a_io_off_when_down: assert property (p_io_off_when_down) // [R7]
		else $error("io regulator left enabled while off");

	property p_buffer_holds_main;
		@(posedge sys_clk) disable iff (reset)
		ao_buffer_out.oe |-> !main_power_on_reset_n;
	endproperty
	a_buffer_holds_main: assert property (p_buffer_holds_main) // [R12]
		else $error("main reset released during always-on fault");

	c_reach_active: cover property (@(posedge sys_clk) disable iff (reset)
		$rose(state_reg == ST_ACTIVE));
	c_reach_standby: cover property (@(posedge sys_clk) disable iff (reset)
		state_reg == ST_ACTIVE ##1 state_reg == ST_STANDBY);
	c_full_off: cover property (@(posedge sys_clk) disable iff (reset)
		state_reg == ST_POWER_DOWN ##1 state_reg == ST_OFF);
	c_sw_off: cover property (@(posedge sys_clk) disable iff (reset)
		sw_off_request && state_reg == ST_ACTIVE ##1 state_reg == ST_POWER_DOWN);

endmodule : pmic_low_power_reset_control

//--- dv/lpm_processor_model.sv
// file: processor model driving the low power mode control pins
`timescale 1ns/100ps
module lpm_processor_model (
	// clock
	input wire logic sys_clk,
	// requests from the bench
	input wire logic want_on,
	input wire logic want_active,
	// controller pins
	output logic controller_enable_in,
	output logic mode_standby_in
);
	initial begin
		controller_enable_in = 1'b0;
		mode_standby_in = 1'b1;
	end
	always @(posedge sys_clk) begin
		controller_enable_in <= want_on;
		mode_standby_in <= want_active;
	end
endmodule : lpm_processor_model

//--- dv/testbench.sv
// file: self-checking bench for the low power reset controller
`timescale 1ns/100ps
module testbench;
	import pmic_lp_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic want_on, want_active, sw_off_request, io_fault;
	logic [3:0] rail_good_in;
	logic io_regulator_good_in, ao_discrete_good_in;
	logic enable_pin, mode_pin, main_n, ao_n;
	rail_ctrl_t rail_ctrl;
	ctrl_state_t ctrl_state;
	od_pin_t ao_pg, io_en, crst, aobuf;
	od_pin_t aobuf_flex;
	logic main_n_flex, ao_n_flex;
	int fail_count = 0;
	int tests_run = 0;
	int seed = 61;
	int r, gap;

	always #5 sys_clk = ~sys_clk;

	lpm_processor_model cpu (.sys_clk(sys_clk), .want_on(want_on), .want_active(want_active),
		.controller_enable_in(enable_pin), .mode_standby_in(mode_pin));

	pmic_low_power_reset_control #(.STEP_CYCLES_P(2), .FLEXIBLE_P(1'b0)) uut (
		.sys_clk(sys_clk), .reset(reset), .controller_enable_in(enable_pin),
		.mode_standby_in(mode_pin), .sw_off_request(sw_off_request),
		.rail_good_in(rail_good_in), .io_regulator_good_in(io_regulator_good_in),
		.ao_discrete_good_in(ao_discrete_good_in), .rail_ctrl(rail_ctrl),
		.ctrl_state(ctrl_state), .always_on_power_good_out(ao_pg),
		.io_regulator_enable_out(io_en), .controller_reset_out_n(crst),
		.ao_buffer_out(aobuf), .main_power_on_reset_n(main_n),
		.always_on_power_on_reset_n(ao_n));

	// same pins, flexible arrangement: only its reset network is compared
	pmic_low_power_reset_control #(.STEP_CYCLES_P(2), .FLEXIBLE_P(1'b1)) uut_flex (
		.sys_clk(sys_clk), .reset(reset), .controller_enable_in(enable_pin),
		.mode_standby_in(mode_pin), .sw_off_request(sw_off_request),
		.rail_good_in(rail_good_in), .io_regulator_good_in(io_regulator_good_in),
		.ao_discrete_good_in(ao_discrete_good_in), .rail_ctrl(),
		.ctrl_state(), .always_on_power_good_out(),
		.io_regulator_enable_out(), .controller_reset_out_n(),
		.ao_buffer_out(aobuf_flex), .main_power_on_reset_n(main_n_flex),
		.always_on_power_on_reset_n(ao_n_flex));

	// regulators report good one cycle after their enable
	always @(posedge sys_clk) begin
		rail_good_in <= rail_ctrl.enable;
		io_regulator_good_in <= !io_en.oe && !io_fault;
	end

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task final_report;
		if (fail_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	// bounded wait, then the state itself is compared
	task wait_state(input ctrl_state_t s);
		int n;
		n = 0;
		while (ctrl_state !== s && n < 60) begin
			@(negedge sys_clk);
			n++;
		end
		chk(8'(ctrl_state), 8'(s));
	endtask : wait_state

	initial begin
		#100000;
		fail_count++;
		final_report();
	end

	initial begin
		want_on = 1'b0;
		want_active = 1'b1;
		sw_off_request = 1'b0;
		io_fault = 1'b0;
		ao_discrete_good_in = 1'b1;
		rail_good_in = 4'h0;
		io_regulator_good_in = 1'b0;
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		@(negedge sys_clk);
		chk(8'(ctrl_state), 8'(ST_OFF));
		chk({4'h0, rail_ctrl.enable}, 8'h00);
		chk({7'h00, main_n}, 8'h00);
		for (r = 0; r < 3; r++) begin
			gap = 1 + ($unsigned($random(seed)) % 8);
			repeat (gap) @(posedge sys_clk);
			want_on <= 1'b1;
			wait_state(ST_ACTIVE);
			chk({3'h0, rail_ctrl}, {3'h0, RAILS_ALL, 1'b1});
			repeat (4) @(negedge sys_clk);
			chk({7'h00, main_n}, 8'h01);
			chk({7'h00, ao_pg.oe}, 8'h00);
			chk({7'h00, io_en.oe}, 8'h00);
			chk({7'h00, crst.oe}, 8'h00);
			@(posedge sys_clk);
			io_fault <= 1'b1;
			repeat (3) @(negedge sys_clk);
			chk({7'h00, main_n}, 8'h00);
			@(posedge sys_clk);
			io_fault <= 1'b0;
			want_active <= 1'b0;
			wait_state(ST_STANDBY);
			chk({3'h0, rail_ctrl}, {3'h0, RAILS_ALL & ~RAILS_STANDBY_OFF, 1'b0});
			repeat (3) @(negedge sys_clk);
			chk({7'h00, ao_pg.oe}, 8'h00);
			chk({7'h00, ao_n}, 8'h01);
			chk({7'h00, main_n}, 8'h00);
			chk({7'h00, crst.oe}, 8'h01);
			@(posedge sys_clk);
			want_active <= 1'b1;
			ao_discrete_good_in <= 1'($random(seed));
			wait_state(ST_ACTIVE);
			chk({4'h0, rail_ctrl.enable}, {4'h0, RAILS_ALL});
			repeat (2) @(negedge sys_clk);
			chk({7'h00, aobuf.oe}, 8'h00);
			chk({7'h00, main_n}, 8'h01);
			chk({7'h00, aobuf_flex.oe}, {7'h00, !ao_discrete_good_in});
			chk({7'h00, ao_n_flex}, {7'h00, ao_discrete_good_in});
			chk({7'h00, main_n_flex}, {7'h00, ao_discrete_good_in});
			@(posedge sys_clk);
			if (r == 1)
				sw_off_request <= 1'b1;
			else
				want_on <= 1'b0;
			wait_state(ST_POWER_DOWN);
			wait_state(ST_OFF);
			chk({4'h0, rail_ctrl.enable}, 8'h00);
			@(posedge sys_clk);
			want_on <= 1'b0;
			repeat (6) @(posedge sys_clk);
			sw_off_request <= 1'b0;
			@(negedge sys_clk);
			chk({7'h00, ao_pg.oe}, 8'h01);
			chk({7'h00, io_en.oe}, 8'h01);
			chk({7'h00, crst.oe}, 8'h01);
			chk({7'h00, main_n}, 8'h00);
		end
		final_report();
	end
endmodule : testbench
